/* aps_pkg.sv */
// Shared constants and types for the axis pulse speed profiler.
package aps_pkg;
    localparam int CLK_NS        = 25;
    localparam int PULSE_HIGH_NS = 500;
    localparam int PULSE_CYC     = (PULSE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RAMP_TICK_NS  = 1000;
    localparam int RAMP_CYC      = RAMP_TICK_NS / CLK_NS;
    localparam int DATA_W        = 16;
    localparam int ADDR_W        = 4;

    localparam logic [3:0] ADDR_CMD     = 4'h0;
    localparam logic [3:0] ADDR_STOPCFG = 4'h1;
    localparam logic [3:0] ADDR_MODE    = 4'h2;
    localparam logic [3:0] ADDR_INIT    = 4'h3;
    localparam logic [3:0] ADDR_DRIVE   = 4'h4;
    localparam logic [3:0] ADDR_ACCEL   = 4'h5;
    localparam logic [3:0] ADDR_DECEL   = 4'h6;
    localparam logic [3:0] ADDR_PULSES  = 4'h7;
    localparam logic [3:0] ADDR_DPOINT  = 4'h8;
    localparam logic [3:0] ADDR_STATUS  = 4'h9;
    localparam logic [3:0] ADDR_SPEED   = 4'hA;

    localparam logic [7:0] CMD_FIX_PLUS   = 8'h20;
    localparam logic [7:0] CMD_FIX_MINUS  = 8'h21;
    localparam logic [7:0] CMD_CONT_PLUS  = 8'h22;
    localparam logic [7:0] CMD_CONT_MINUS = 8'h23;
    localparam logic [7:0] CMD_DEC_STOP   = 8'h26;
    localparam logic [7:0] CMD_SUD_STOP   = 8'h27;
    localparam logic [7:0] CMD_SET_DPOINT = 8'h07;

    localparam logic [15:0] STOPCFG_RST = 16'h0000;
    localparam logic [15:0] MODE_RST    = 16'h0000;
    localparam logic [15:0] PARAM_RST   = 16'h0000;
    localparam logic [5:0]  STOPCFG_MSK = 6'h3F;

    typedef struct packed {
        logic [9:0] rsvd_hi;
        logic       tri_prev;
        logic [2:0] rsvd_mid;
        logic       separate_decel_enable;
        logic       manual_decel_point_select;
    } aps_mode_t;

    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_ACC   = 2'b01,
        PH_CONST = 2'b10,
        PH_DEC   = 2'b11
    } aps_phase_t;
endpackage

/* aps_pulse_gen.sv */
// Rate accumulator that emits whole drive pulses of fixed width.
`timescale 1ns/1ps
module aps_pulse_gen #(
    parameter int SPD_W = 16,
    parameter int ACC_W = 24,
    parameter int PW    = aps_pkg::PULSE_CYC
) (
    // Clock and reset.
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    // Rate control.
    input  wire logic [SPD_W-1:0] speed,
    input  wire logic             run,
    // Pulse side.
    output logic                  pulse_q,
    output logic                  start,
    output logic                  busy
);
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W:0]   acc_sum;
    logic [7:0]       width_q;

    assign acc_sum = {1'b0, acc_q} + {{(ACC_W + 1 - SPD_W){1'b0}}, speed};
    assign busy    = pulse_q;
    // A pulse only begins when none is running, so a stop never cuts one short.
    assign start   = run && acc_sum[ACC_W] && !pulse_q;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            acc_q <= '0;
        end else if (!run) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_sum[ACC_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pulse_q <= 1'b0;
            width_q <= 8'h00;
        end else if (start) begin
            pulse_q <= 1'b1;
            width_q <= 8'(PW - 1);
        end else if (width_q != 8'h00) begin
            width_q <= width_q - 8'h01;
        end else begin
            pulse_q <= 1'b0;
        end
    end
endmodule // aps_pulse_gen

/* aps_profiler.sv */
// Single-axis speed profiler with register port, halt inputs and pulse output.
`timescale 1ns/1ps
// How it works
// - Continuous driving emits pulses until a stop command or enabled halt input.
// - Drive speed may change during continuous driving; the rate follows it.
// - Two stop commands: decelerating stop ramps down in ramped driving, sudden stop ends at once.
// - Three halt inputs, each with enable and active-level bits in bits 5..0.
// - A halt input during ramped continuous driving gives a decelerating stop.
// - A halt input during constant-speed driving gives a sudden stop.
// - Fixed or continuous command starts plus or minus driving in the chosen mode.
// - Drive speed not above initial speed means constant speed, no ramps.
// - Acceleration raises speed linearly from initial speed up to drive speed.
// - Symmetric fixed driving decelerates when remaining pulses drop below acceleration pulses.
// - Deceleration uses the same slope down to initial speed; ends after all pulses.
// - Stop during acceleration or short counts decelerate from the current speed.
// - Triangle prevention holds speed once acceleration pulses exceed a quarter of the total.
// - Triangle prevention is off after reset, on by mode bit 5.
// - Non-symmetric fixed driving computes its deceleration point from count and rates.
// - Mode bit 1 selects the separate deceleration rate while decelerating.
// - Mode bit 0 clear selects the automatic deceleration point.
module aps_profiler #(
    parameter int DW = aps_pkg::DATA_W,
    parameter int AW = aps_pkg::ADDR_W
) (
    // Clock and reset.
    input  wire logic          ref_clk,
    input  wire logic          reset_n,
    // Register port.
    input  wire logic [AW-1:0] reg_addr,
    input  wire logic [DW-1:0] reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [DW-1:0] reg_rdata_q,
    // Halt pins, index 2 carries Z-phase, 1 home, 0 near home.
    input  wire logic [2:0]    external_halt_inputs,
    // Motor driver side.
    output logic               drive_pulse,
    output logic               direction_q,
    output logic               driving_q
);
    aps_pkg::aps_mode_t  mode_q;
    aps_pkg::aps_phase_t phase_q, phase_d;
    logic [5:0]    stopcfg_q;
    logic [DW-1:0] init_q, drive_q, accel_q, decel_q, total_q, dpoint_q, man_pt_q;
    logic [DW-1:0] speed_q, speed_d, rem_q, acc_cnt_q;
    logic [31:0]   wacc_q;
    logic          fixed_q, const_q, stopping_q;
    logic [2:0]    halt_s1_q, halt_s2_q;
    logic [7:0]    tick_cnt_q;
    logic          tick;

    // Register decode.
    wire wr_cmd    = reg_wr && (reg_addr == aps_pkg::ADDR_CMD);
    wire [7:0] cmd = reg_wdata[7:0];
    wire cmd_start = wr_cmd && !driving_q && (cmd[7:2] == aps_pkg::CMD_FIX_PLUS[7:2]);
    wire cmd_fix   = !cmd[1];
    wire cmd_dstop = wr_cmd && (cmd == aps_pkg::CMD_DEC_STOP);
    wire cmd_sstop = wr_cmd && (cmd == aps_pkg::CMD_SUD_STOP);
    wire cmd_dpt   = wr_cmd && (cmd == aps_pkg::CMD_SET_DPOINT);

    // Halt inputs: enable at bit 2i, active-high level at bit 2i+1.
    wire [2:0] halt_en  = {stopcfg_q[4], stopcfg_q[2], stopcfg_q[0]};
    wire [2:0] halt_lvl = {stopcfg_q[5], stopcfg_q[3], stopcfg_q[1]};
    wire halt_hit = driving_q && |(halt_en & ~(halt_s2_q ^ halt_lvl));

    // Profile arithmetic.
    wire [DW-1:0] dec_rate = mode_q.separate_decel_enable ? decel_q : accel_q;
    wire [DW-1:0] floor_v  = (stopping_q || fixed_q || drive_q < init_q) ? init_q : drive_q;
    wire [DW:0]   acc_sum  = {1'b0, speed_q} + {1'b0, accel_q};
    wire [DW:0]   dec_dif  = {1'b0, speed_q} - {1'b0, dec_rate};
    wire [31:0]   rem_w    = rem_q * dec_rate;
    wire auto_dec  = !mode_q.manual_decel_point_select && (rem_w < wacc_q);
    wire man_dec   = mode_q.manual_decel_point_select && (rem_q <= man_pt_q);
    wire need_dec  = fixed_q && (auto_dec || man_dec);
    wire tri_hold  = mode_q.tri_prev && fixed_q && ({acc_cnt_q, 2'b00} > {2'b00, total_q});
    wire fix_done  = fixed_q && (rem_q == '0);
    wire run       = driving_q && !fix_done;
    wire p_start;
    wire p_busy;

    aps_pulse_gen #(
        .SPD_W (DW)
    ) u_pulse (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .speed   (speed_q),
        .run     (run),
        .pulse_q (drive_pulse),
        .start   (p_start),
        .busy    (p_busy)
    );

    // Ramp update rate divider.
    assign tick = (tick_cnt_q == 8'(aps_pkg::RAMP_CYC - 1));

    always_ff @(posedge ref_clk) begin
        if (!reset_n || tick) begin
            tick_cnt_q <= 8'h00;
        end else begin
            tick_cnt_q <= tick_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            halt_s1_q <= 3'b000;
            halt_s2_q <= 3'b000;
        end else begin
            halt_s1_q <= external_halt_inputs;
            halt_s2_q <= halt_s1_q;
        end
    end

    // Register file writes.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            stopcfg_q <= aps_pkg::STOPCFG_RST[5:0];
            mode_q    <= aps_pkg::MODE_RST;
            init_q    <= aps_pkg::PARAM_RST;
            drive_q   <= aps_pkg::PARAM_RST;
            accel_q   <= aps_pkg::PARAM_RST;
            decel_q   <= aps_pkg::PARAM_RST;
            total_q   <= aps_pkg::PARAM_RST;
            dpoint_q  <= aps_pkg::PARAM_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                aps_pkg::ADDR_STOPCFG: stopcfg_q <= reg_wdata[5:0] & aps_pkg::STOPCFG_MSK;
                aps_pkg::ADDR_MODE:    mode_q    <= reg_wdata;
                aps_pkg::ADDR_INIT:    init_q    <= reg_wdata;
                aps_pkg::ADDR_DRIVE:   drive_q   <= reg_wdata;
                aps_pkg::ADDR_ACCEL:   accel_q   <= reg_wdata;
                aps_pkg::ADDR_DECEL:   decel_q   <= reg_wdata;
                aps_pkg::ADDR_PULSES:  total_q   <= reg_wdata;
                aps_pkg::ADDR_DPOINT:  dpoint_q  <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Register reads, answered one cycle later.
    wire [DW-1:0] status_w = {10'h000, halt_s2_q, p_busy, phase_q};
    wire [DW-1:0] rd_mux =
        (reg_addr == aps_pkg::ADDR_STOPCFG) ? {10'h000, stopcfg_q} :
        (reg_addr == aps_pkg::ADDR_MODE)    ? mode_q :
        (reg_addr == aps_pkg::ADDR_INIT)    ? init_q :
        (reg_addr == aps_pkg::ADDR_DRIVE)   ? drive_q :
        (reg_addr == aps_pkg::ADDR_ACCEL)   ? accel_q :
        (reg_addr == aps_pkg::ADDR_DECEL)   ? decel_q :
        (reg_addr == aps_pkg::ADDR_PULSES)  ? rem_q :
        (reg_addr == aps_pkg::ADDR_DPOINT)  ? man_pt_q :
        (reg_addr == aps_pkg::ADDR_STATUS)  ? status_w :
        (reg_addr == aps_pkg::ADDR_SPEED)   ? speed_q : '0;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            reg_rdata_q <= '0;
        end else begin
            reg_rdata_q <= reg_rd ? rd_mux : '0;
        end
    end

    // Phase sequencing.
    always_comb begin
        phase_d = phase_q;
        speed_d = speed_q;
        unique case (phase_q)
            aps_pkg::PH_IDLE: begin
                if (cmd_start && drive_q <= init_q) begin
                    phase_d = aps_pkg::PH_CONST;
                    speed_d = drive_q;
                end else if (cmd_start) begin
                    phase_d = aps_pkg::PH_ACC;
                    speed_d = init_q;
                end
            end
            aps_pkg::PH_ACC: begin
                if (stopping_q || need_dec) begin
                    phase_d = aps_pkg::PH_DEC;
                end else if (tri_hold || drive_q < speed_q) begin
                    phase_d = (drive_q < speed_q) ? aps_pkg::PH_DEC : aps_pkg::PH_CONST;
                end else if (tick) begin
                    speed_d = (acc_sum > {1'b0, drive_q}) ? drive_q : acc_sum[DW-1:0];
                    if (acc_sum >= {1'b0, drive_q}) begin
                        phase_d = aps_pkg::PH_CONST;
                    end
                end
            end
            aps_pkg::PH_CONST: begin
                if (const_q) begin
                    speed_d = drive_q;
                end else if (stopping_q || need_dec || drive_q < speed_q) begin
                    phase_d = aps_pkg::PH_DEC;
                end else if (!fixed_q && drive_q > speed_q) begin
                    phase_d = aps_pkg::PH_ACC;
                end
            end
            aps_pkg::PH_DEC: begin
                if (!fixed_q && !stopping_q && drive_q > speed_q) begin
                    phase_d = aps_pkg::PH_ACC;
                end else if (tick) begin
                    if (dec_dif[DW] || dec_dif[DW-1:0] <= floor_v) begin
                        speed_d = floor_v;
                        if (!stopping_q && !fixed_q) begin
                            phase_d = aps_pkg::PH_CONST;
                        end
                    end else begin
                        speed_d = dec_dif[DW-1:0];
                    end
                end
            end
        endcase
    end

    wire dec_stop_end = stopping_q && phase_q == aps_pkg::PH_DEC && speed_q <= init_q;
    wire end_now = cmd_sstop || fix_done || dec_stop_end ||
                   (halt_hit && const_q) || (cmd_dstop && const_q);

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            phase_q     <= aps_pkg::PH_IDLE;
            speed_q     <= '0;
            driving_q   <= 1'b0;
            direction_q <= 1'b0;
            fixed_q     <= 1'b0;
            const_q     <= 1'b0;
            stopping_q  <= 1'b0;
        end else if (cmd_start) begin
            phase_q     <= phase_d;
            speed_q     <= speed_d;
            driving_q   <= 1'b1;
            direction_q <= cmd[0];
            fixed_q     <= cmd_fix;
            const_q     <= drive_q <= init_q;
            stopping_q  <= 1'b0;
        end else if (driving_q && end_now) begin
            phase_q    <= aps_pkg::PH_IDLE;
            driving_q  <= 1'b0;
            stopping_q <= 1'b0;
        end else if (driving_q) begin
            phase_q    <= phase_d;
            speed_q    <= speed_d;
            stopping_q <= stopping_q || cmd_dstop || halt_hit;
        end
    end

    // Pulse accounting for the deceleration points, triangle prevention and fixed count.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rem_q     <= '0;
            acc_cnt_q <= '0;
            wacc_q    <= '0;
            man_pt_q  <= '0;
        end else begin
            if (cmd_dpt) begin
                man_pt_q <= dpoint_q;
            end
            if (cmd_start) begin
                rem_q     <= total_q;
                acc_cnt_q <= '0;
                wacc_q    <= '0;
            end else if (p_start) begin
                rem_q <= fixed_q ? rem_q - 1'b1 : rem_q;
                if (phase_q == aps_pkg::PH_ACC) begin
                    acc_cnt_q <= acc_cnt_q + 1'b1;
                    wacc_q    <= wacc_q + {16'h0000, accel_q};
                end
            end
        end
    end

    localparam int PW_A = aps_pkg::PULSE_CYC;

    a_pulse_whole: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(drive_pulse) |-> drive_pulse [*2] ##(PW_A - 2) drive_pulse ##1 !drive_pulse)
        else $error("drive pulse width wrong");
    a_sudden_end: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (driving_q && cmd_sstop) |=> !driving_q && phase_q == aps_pkg::PH_IDLE)
        else $error("sudden stop did not end driving");
    a_const_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (cmd_start && drive_q <= init_q) |=> phase_q == aps_pkg::PH_CONST && speed_q == drive_q)
        else $error("constant start wrong");
    a_cont_keeps: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (driving_q && !fixed_q && !wr_cmd && !halt_hit && !stopping_q) |=> driving_q)
        else $error("continuous drive ended early");
    a_halt_const: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (halt_hit && const_q && !wr_cmd) |=> !driving_q)
        else $error("halt did not stop constant drive");
    a_halt_ramp: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (halt_hit && !const_q && !wr_cmd && !end_now) |=> stopping_q && driving_q)
        else $error("halt did not start decelerating stop");
    a_tri_reset: assert property (@(posedge ref_clk)
        $rose(reset_n) |-> !mode_q.tri_prev)
        else $error("triangle prevention on after reset");
    a_acc_ceiling: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (phase_q == aps_pkg::PH_ACC && tick && !need_dec && !stopping_q && !tri_hold
         && drive_q >= speed_q && !wr_cmd)
        |=> speed_q == ($past(acc_sum) > {1'b0, $past(drive_q)} ? $past(drive_q)
                        : $past(acc_sum[DW-1:0])))
        else $error("acceleration step wrong");
    a_fixed_end: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (driving_q && fix_done && !cmd_start) |=> !driving_q)
        else $error("fixed drive did not end at zero count");
    a_sep_rate: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (phase_q == aps_pkg::PH_DEC && tick && !end_now && !wr_cmd && !reg_wr
         && mode_q.separate_decel_enable && !dec_dif[DW] && dec_dif[DW-1:0] > floor_v
         && (fixed_q || stopping_q || drive_q <= speed_q))
        |=> speed_q == $past(speed_q) - $past(decel_q))
        else $error("deceleration rate not taken from decel register");
endmodule // aps_profiler

/* aps_motor_model.sv */
// Motor driver and sensor model that counts and times drive pulses.
`timescale 1ns/1ps
module aps_motor_model (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Pulse side.
    input  wire logic        drive_pulse,
    // Sensor hits: 2 Z-phase, 1 home, 0 near home.
    input  wire logic [2:0]  sensor_hit,
    output logic      [2:0]  halt_pins,
    // Observations.
    output logic      [15:0] pulse_cnt,
    output logic      [7:0]  width_errs
);
    int   hi_len;
    logic last_q;
    // The Z-phase pin is active low, the home pins active high.
    assign halt_pins = {~sensor_hit[2], sensor_hit[1:0]};
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            pulse_cnt <= 16'h0000;
            width_errs <= 8'h00;
            hi_len <= 0;
            last_q <= 1'b0;
        end else begin
            last_q <= drive_pulse;
            if (drive_pulse) begin
                hi_len <= hi_len + 1;
            end
            if (drive_pulse && !last_q) begin
                pulse_cnt <= pulse_cnt + 16'h0001;
            end
            if (!drive_pulse && last_q) begin
                hi_len <= 0;
                if (hi_len != aps_pkg::PULSE_CYC) begin
                    width_errs <= width_errs + 8'h01;
                end
            end
        end
    end
endmodule // aps_motor_model

/* tb_axis_pulse_speed_profiler.sv */
// Self-checking bench for the axis pulse speed profiler.
`timescale 1ns/1ps
module tb_axis_pulse_speed_profiler;
    typedef struct packed {
        logic [3:0]  a;
        logic [15:0] w;
        logic [15:0] e;
    } aps_row_t;
    logic        ref_clk;
    logic        reset_n;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata_q;
    logic [15:0] rd_v;
    logic [2:0]  sensor_hit;
    logic [2:0]  halt_pins;
    logic        drive_pulse;
    logic        direction_q;
    logic        driving_q;
    logic [15:0] pulse_cnt;
    logic [15:0] p0;
    logic [7:0]  width_errs;
    int          num_errors = 0;
    int          n_tests = 0;
    aps_row_t    rows [8] = '{
        '{aps_pkg::ADDR_STOPCFG, 16'h002A, 16'h002A},
        '{aps_pkg::ADDR_MODE, 16'h0023, 16'h0023},
        '{aps_pkg::ADDR_INIT, 16'h1234, 16'h1234},
        '{aps_pkg::ADDR_DRIVE, 16'h4321, 16'h4321},
        '{aps_pkg::ADDR_ACCEL, 16'h0055, 16'h0055},
        '{aps_pkg::ADDR_DECEL, 16'h00AA, 16'h00AA},
        '{4'hF, 16'hBEEF, 16'h0000},
        '{aps_pkg::ADDR_SPEED, 16'h5555, 16'h0000}};

    aps_profiler i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .external_halt_inputs(halt_pins),
        .drive_pulse(drive_pulse), .direction_q(direction_q), .driving_q(driving_q));
    aps_motor_model i_motor (.ref_clk(ref_clk), .reset_n(reset_n),
        .drive_pulse(drive_pulse), .sensor_hit(sensor_hit), .halt_pins(halt_pins),
        .pulse_cnt(pulse_cnt), .width_errs(width_errs));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic end_sim();
        if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata_q;
    endtask
    // Starts a drive and checks the outputs one edge after the command.
    task automatic start(logic [7:0] cmd, logic dir);
        wr(aps_pkg::ADDR_CMD, {8'h00, cmd});
        @(posedge ref_clk);
        #1 chk("driving", {15'h0000, driving_q}, 16'h0001);
        chk("direction", {15'h0000, direction_q}, {15'h0000, dir});
        p0 = pulse_cnt;
    endtask
    task automatic wait_phase(logic [1:0] ph, int lim);
        for (int i = 0; i < lim; i++) begin
            rd(aps_pkg::ADDR_STATUS);
            if (rd_v[1:0] === ph) return;
        end
        num_errors++;
        $display("BAD phase expected %h seen %h", ph, rd_v[1:0]);
        end_sim();
    endtask
    task automatic wait_idle(int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge ref_clk);
            #1 if (driving_q === 1'b0) return;
        end
        num_errors++;
        $display("BAD idle expected 0 seen %b", driving_q);
        end_sim();
    endtask

    initial begin
        reset_n = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sensor_hit = 3'b000;
        repeat (20) @(posedge ref_clk);
        #1 chk("reset outs", {13'h0000, drive_pulse, direction_q, driving_q}, 16'h0000);
        reset_n <= 1'b1;
        rd(aps_pkg::ADDR_MODE);
        chk("mode reset", rd_v, aps_pkg::MODE_RST);
        rd(aps_pkg::ADDR_STOPCFG);
        chk("stopcfg reset", rd_v, aps_pkg::STOPCFG_RST);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a);
            chk("reg readback", rd_v, rows[i].e);
        end
        // Constant speed continuous drive, speed change, sudden stop.
        wr(aps_pkg::ADDR_MODE, 16'h0000);
        wr(aps_pkg::ADDR_STOPCFG, 16'h0000);
        wr(aps_pkg::ADDR_INIT, 16'h8000);
        wr(aps_pkg::ADDR_DRIVE, 16'h6000);
        start(aps_pkg::CMD_CONT_PLUS, 1'b0);
        wait_phase(aps_pkg::PH_CONST, 3);
        rd(aps_pkg::ADDR_SPEED);
        chk("const speed", rd_v, 16'h6000);
        repeat (2100) @(posedge ref_clk);
        chk("run pulses", {15'h0000, (pulse_cnt - p0) >= 16'h0003}, 16'h0001);
        wr(aps_pkg::ADDR_DRIVE, 16'h7000);
        rd(aps_pkg::ADDR_SPEED);
        chk("new speed", rd_v, 16'h7000);
        wr(aps_pkg::ADDR_CMD, {8'h00, aps_pkg::CMD_SUD_STOP});
        @(posedge ref_clk);
        #1 chk("sudden stop", {15'h0000, driving_q}, 16'h0000);
        p0 = pulse_cnt;
        repeat (1500) @(posedge ref_clk);
        chk("no pulse after stop", pulse_cnt, p0);
        // Home halt in constant mode stops at once.
        wr(aps_pkg::ADDR_STOPCFG, 16'h000C);
        start(aps_pkg::CMD_CONT_MINUS, 1'b1);
        repeat (100) @(posedge ref_clk);
        sensor_hit <= 3'b010;
        wait_idle(8);
        sensor_hit <= 3'b000;
        // Symmetric fixed ramp drive.
        wr(aps_pkg::ADDR_STOPCFG, 16'h0000);
        wr(aps_pkg::ADDR_INIT, 16'h2000);
        wr(aps_pkg::ADDR_DRIVE, 16'h8000);
        wr(aps_pkg::ADDR_ACCEL, 16'h0100);
        wr(aps_pkg::ADDR_PULSES, 16'h000C);
        start(aps_pkg::CMD_FIX_MINUS, 1'b1);
        wait_phase(aps_pkg::PH_ACC, 3);
        wait_phase(aps_pkg::PH_DEC, 20000);
        wait_idle(40000);
        chk("fixed count", pulse_cnt - p0, 16'h000C);
        rd(aps_pkg::ADDR_PULSES);
        chk("remaining", rd_v, 16'h0000);
        // Triangle prevention holds constant speed below drive speed.
        wr(aps_pkg::ADDR_MODE, 16'h0020);
        wr(aps_pkg::ADDR_PULSES, 16'h0008);
        start(aps_pkg::CMD_FIX_PLUS, 1'b0);
        wait_phase(aps_pkg::PH_CONST, 20000);
        rd(aps_pkg::ADDR_SPEED);
        chk("held speed", {15'h0000, rd_v < 16'h8000}, 16'h0001);
        wait_idle(40000);
        chk("tri count", pulse_cnt - p0, 16'h0008);
        // Decelerating stop while accelerating.
        wr(aps_pkg::ADDR_MODE, 16'h0000);
        start(aps_pkg::CMD_CONT_PLUS, 1'b0);
        wait_phase(aps_pkg::PH_ACC, 3);
        repeat (100) @(posedge ref_clk);
        wr(aps_pkg::ADDR_CMD, {8'h00, aps_pkg::CMD_DEC_STOP});
        wait_phase(aps_pkg::PH_DEC, 3);
        wait_idle(40000);
        // Z-phase halt, active low, during ramped continuous drive.
        wr(aps_pkg::ADDR_STOPCFG, 16'h0010);
        start(aps_pkg::CMD_CONT_PLUS, 1'b0);
        wait_phase(aps_pkg::PH_ACC, 3);
        repeat (100) @(posedge ref_clk);
        sensor_hit <= 3'b100;
        wait_phase(aps_pkg::PH_DEC, 5);
        wait_idle(40000);
        sensor_hit <= 3'b000;
        // Manual deceleration point preset.
        wr(aps_pkg::ADDR_MODE, 16'h0001);
        wr(aps_pkg::ADDR_DPOINT, 16'h0009);
        wr(aps_pkg::ADDR_CMD, {8'h00, aps_pkg::CMD_SET_DPOINT});
        rd(aps_pkg::ADDR_DPOINT);
        chk("decel point", rd_v, 16'h0009);
        // Manual point with the separate deceleration rate on a fixed drive.
        wr(aps_pkg::ADDR_MODE, 16'h0003);
        wr(aps_pkg::ADDR_PULSES, 16'h000C);
        start(aps_pkg::CMD_FIX_PLUS, 1'b0);
        wait_phase(aps_pkg::PH_DEC, 20000);
        rd(aps_pkg::ADDR_PULSES);
        chk("manual point", rd_v, 16'h0009);
        wait_idle(40000);
        chk("manual count", pulse_cnt - p0, 16'h000C);
        chk("pulse widths", {8'h00, width_errs}, 16'h0000);
        // Reset in mid-drive clears the outputs and triangle prevention.
        wr(aps_pkg::ADDR_MODE, 16'h0020);
        start(aps_pkg::CMD_FIX_MINUS, 1'b1);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        #1 chk("reset 2", {13'h0000, drive_pulse, direction_q, driving_q}, 16'h0000);
        rd(aps_pkg::ADDR_MODE);
        chk("mode after reset", rd_v, aps_pkg::MODE_RST);
        end_sim();
    end
endmodule // tb_axis_pulse_speed_profiler
